// ---- logic/pmt_pkg.sv ----
// constants and state type shared by the pulse modulator timer
package pmt_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_CTL = 10'h0cc;
  localparam logic [9:0] IDX_RELOAD = 10'h0cf;
  localparam logic [9:0] IDX_STAT = 10'h0d0;
  // control register fields
  localparam int RUN_BIT = 0;
  localparam int CSEL_BIT = 1;
  localparam int MSEL_BIT = 2;
  // status register fields
  localparam int STAT_CNT_LSB = 0;
  localparam int STAT_PIN_BIT = 8;
  localparam int STAT_RUN_BIT = 9;
  // reset values
  localparam logic [7:0] RELOAD_RST = 8'h00;
  localparam logic [7:0] CNT_RST = 8'h00;
  // oscillator cycles per instruction cycle
  localparam int TC_DIV = 10;
  localparam int TC_DIV_W = 4;
  localparam int ADDR_W = 12;

  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] reload;
    logic run;
    logic csel;
    logic msel;
    logic pin;
    logic ack;
    logic [31:0] rdat;
  } pmt_state_t;
endpackage

// ---- logic/pmt_div.sv ----
// instruction-cycle enable divider
`timescale 1ns/1ps
module pmt_div #(
  parameter int DIV = pmt_pkg::TC_DIV,
  parameter int W = pmt_pkg::TC_DIV_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // one-cycle enable every DIV clocks
  output logic tick_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } pmt_div_t;

  pmt_div_t st_ff;
  pmt_div_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (st_ff.cnt == W'(DIV - 1)) begin
      nxt_st.cnt = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick_o = st_ff.tick;
endmodule

// ---- logic/pmt_top.sv ----
// pulse modulator timer with wishbone register slave
`timescale 1ns/1ps
module pmt_top #(
  parameter int ADDR_W = pmt_pkg::ADDR_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // main 16-bit timer underflow pulse
  input wire logic timer_underflow_i,
  // modulator output pin
  output logic pulse_output_pin_o,
  output logic pulse_output_en_o
);
  pmt_pkg::pmt_state_t st_ff;
  pmt_pkg::pmt_state_t nxt_st;

  logic tc_tick;
  logic req;
  logic wr_acc;
  logic hit_ctl;
  logic hit_reload;
  logic hit_stat;
  logic wr_ctl;
  logic wr_reload;
  logic sw_set;
  logic sw_clr;
  logic hw_set;
  logic vd_mode;
  logic half_mode;
  logic step;

  // register index of a bus address
  function automatic logic [9:0] reg_idx(input logic [ADDR_W-1:0] a);
    reg_idx = 10'(a[ADDR_W-1:2]);
  endfunction

  // counter enable for the selected input clock
  function automatic logic count_en(
    input logic msel,
    input logic csel,
    input logic tc
  );
    // only the oscillator-fed burst counts every cycle
    count_en = (msel && csel) ? 1'b1 : tc;
  endfunction

  pmt_div #(
    .DIV(pmt_pkg::TC_DIV),
    .W(pmt_pkg::TC_DIV_W)
  ) u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(tc_tick)
  );

  assign req = cyc_i && stb_i;
  // a write lands on the edge where ack is seen high
  assign wr_acc = req && we_i && st_ff.ack;
  assign hit_ctl = (reg_idx(adr_i) == pmt_pkg::IDX_CTL);
  assign hit_reload = (reg_idx(adr_i) == pmt_pkg::IDX_RELOAD);
  assign hit_stat = (reg_idx(adr_i) == pmt_pkg::IDX_STAT);
  assign wr_ctl = wr_acc && hit_ctl && sel_i[0];
  assign wr_reload = wr_acc && hit_reload && sel_i[0];
  assign sw_set = wr_ctl && dat_i[pmt_pkg::RUN_BIT] && !st_ff.run;
  assign sw_clr = wr_ctl && !dat_i[pmt_pkg::RUN_BIT];
  assign vd_mode = !st_ff.msel && st_ff.csel;
  assign half_mode = !st_ff.msel && !st_ff.csel;
  assign hw_set = vd_mode && timer_underflow_i;
  assign step = st_ff.run && count_en(st_ff.msel, st_ff.csel, tc_tick);

  always_comb begin
    nxt_st = st_ff;
    // bus answer: one cycle of ack per request
    nxt_st.ack = req && !st_ff.ack;
    nxt_st.rdat = 32'h0000_0000;
    if (req && !st_ff.ack && !we_i) begin
      if (hit_ctl) begin
        nxt_st.rdat[pmt_pkg::RUN_BIT] = st_ff.run;
        nxt_st.rdat[pmt_pkg::CSEL_BIT] = st_ff.csel;
        nxt_st.rdat[pmt_pkg::MSEL_BIT] = st_ff.msel;
      end else if (hit_reload) begin
        nxt_st.rdat[7:0] = st_ff.reload;
      end else if (hit_stat) begin
        nxt_st.rdat[pmt_pkg::STAT_CNT_LSB +: 8] = st_ff.cnt;
        nxt_st.rdat[pmt_pkg::STAT_PIN_BIT] = st_ff.pin;
        nxt_st.rdat[pmt_pkg::STAT_RUN_BIT] = st_ff.run;
      end else begin
        nxt_st.rdat = 32'h0000_0000;
      end
    end

    // counting
    if (step) begin
      if (st_ff.cnt == 8'h00) begin
        if (st_ff.msel) begin
          nxt_st.run = 1'b0;
        end else if (st_ff.csel) begin
          nxt_st.run = 1'b0;
        end else begin
          nxt_st.cnt = st_ff.reload;
          nxt_st.pin = !st_ff.pin;
        end
      end else begin
        nxt_st.cnt = st_ff.cnt - 8'h01;
      end
    end

    // modulator passes one pulse per input clock step
    if (st_ff.msel) begin
      nxt_st.pin = step;
    end

    if (wr_reload) begin
      nxt_st.reload = dat_i[7:0];
    end

    if (wr_ctl) begin
      nxt_st.csel = dat_i[pmt_pkg::CSEL_BIT];
      nxt_st.msel = dat_i[pmt_pkg::MSEL_BIT];
    end

    if (sw_clr) begin
      // counter freezes on the same edge, no late decrement
      nxt_st.run = 1'b0;
      nxt_st.cnt = st_ff.cnt;
    end else if (sw_set) begin
      nxt_st.run = 1'b1;
      nxt_st.cnt = st_ff.reload;
      nxt_st.pin = 1'b0;
    end

    // timer underflow wins over a clear in the same cycle
    if (hw_set) begin
      nxt_st.run = 1'b1;
      nxt_st.cnt = st_ff.reload;
      nxt_st.pin = 1'b1;
    end

    // a stopped pulse-width timer holds the pin low
    if (!nxt_st.run && !st_ff.msel) begin
      nxt_st.pin = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
      st_ff.reload <= pmt_pkg::RELOAD_RST;
      st_ff.cnt <= pmt_pkg::CNT_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dat_o = st_ff.rdat;
  assign ack_o = st_ff.ack;
  assign pulse_output_pin_o = st_ff.pin;
  // pin is released to the port whenever all control bits are zero
  assign pulse_output_en_o = st_ff.run || st_ff.csel || st_ff.msel;

  // ---------------- assertions ----------------

  property p_ack_once;
    @(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack held for more than one cycle");

  property p_reload_wr;
    @(posedge clk_i) disable iff (rst_i)
      wr_reload |=> (st_ff.reload == $past(dat_i[7:0]));
  endproperty
  a_reload_wr: assert property (p_reload_wr)
    else $error("reload value not stored");

  property p_tc_period;
    @(posedge clk_i) disable iff (rst_i)
      tc_tick |=> (!tc_tick) [*8] ##1 !tc_tick ##1 tc_tick;
  endproperty
  a_tc_period: assert property (p_tc_period)
    else $error("instruction cycle enable not every ten clocks");

  property p_sw_start;
    @(posedge clk_i) disable iff (rst_i)
      (sw_set && !hw_set) |=> (st_ff.run && st_ff.cnt == $past(st_ff.reload));
  endproperty
  a_sw_start: assert property (p_sw_start)
    else $error("run set did not load the counter");

  property p_cki_step;
    @(posedge clk_i) disable iff (rst_i)
      (st_ff.run && st_ff.msel && st_ff.csel && st_ff.cnt != 8'h00 && !wr_ctl)
        |=> (st_ff.cnt == $past(st_ff.cnt) - 8'h01);
  endproperty
  a_cki_step: assert property (p_cki_step)
    else $error("oscillator burst did not count every cycle");

  property p_mod_end;
    @(posedge clk_i) disable iff (rst_i)
      (step && st_ff.msel && st_ff.cnt == 8'h00 && !wr_ctl)
        |=> !st_ff.run ##1 (!pulse_output_pin_o || st_ff.run);
  endproperty
  a_mod_end: assert property (p_mod_end)
    else $error("modulator underflow did not stop the burst");

  property p_sw_stop;
    @(posedge clk_i) disable iff (rst_i)
      (sw_clr && !hw_set) |=> (!st_ff.run && st_ff.cnt == $past(st_ff.cnt));
  endproperty
  a_sw_stop: assert property (p_sw_stop)
    else $error("clearing run did not freeze the counter");

  property p_half_toggle;
    @(posedge clk_i) disable iff (rst_i)
      (step && half_mode && st_ff.cnt == 8'h00 && !wr_ctl)
        |=> (pulse_output_pin_o != $past(st_ff.pin))
            && (st_ff.cnt == $past(st_ff.reload)) && st_ff.run;
  endproperty
  a_half_toggle: assert property (p_half_toggle)
    else $error("square wave did not toggle and reload");

  property p_vd_start;
    @(posedge clk_i) disable iff (rst_i)
      hw_set |=> (st_ff.run && pulse_output_pin_o
                  && st_ff.cnt == $past(st_ff.reload));
  endproperty
  a_vd_start: assert property (p_vd_start)
    else $error("timer underflow did not start the pulse");

  property p_vd_end;
    @(posedge clk_i) disable iff (rst_i)
      (step && vd_mode && st_ff.cnt == 8'h00 && !hw_set && !wr_ctl)
        |=> (!st_ff.run && !pulse_output_pin_o);
  endproperty
  a_vd_end: assert property (p_vd_end)
    else $error("variable duty pulse did not end");

  property p_reset_clear;
    @(posedge clk_i)
      rst_i |=> (!st_ff.run && !st_ff.csel && !st_ff.msel && !pulse_output_en_o);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("reset left control bits set");

  property p_tc_hold;
    @(posedge clk_i) disable iff (rst_i)
      (st_ff.run && !(st_ff.msel && st_ff.csel) && !tc_tick && !wr_ctl && !hw_set)
        |=> (st_ff.cnt == $past(st_ff.cnt));
  endproperty
  a_tc_hold: assert property (p_tc_hold)
    else $error("tc counter moved without an enable");

  property p_mode_bits;
    @(posedge clk_i) disable iff (rst_i)
      wr_ctl |=> (st_ff.msel == $past(dat_i[pmt_pkg::MSEL_BIT]))
                 && (st_ff.csel == $past(dat_i[pmt_pkg::CSEL_BIT]));
  endproperty
  a_mode_bits: assert property (p_mode_bits)
    else $error("mode bits not written");

  property p_ack_answer;
    @(posedge clk_i) disable iff (rst_i)
      (req && !ack_o) |=> ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer)
    else $error("request not acknowledged in the next cycle");

  property p_dat_idle;
    @(posedge clk_i) disable iff (rst_i)
      !ack_o |-> (dat_o == 32'h0000_0000);
  endproperty
  a_dat_idle: assert property (p_dat_idle)
    else $error("read data not zero outside ack");

  property p_rerun_hold;
    @(posedge clk_i) disable iff (rst_i)
      (wr_ctl && dat_i[pmt_pkg::RUN_BIT] && st_ff.run && !step && !hw_set)
        |=> (st_ff.run && st_ff.cnt == $past(st_ff.cnt));
  endproperty
  a_rerun_hold: assert property (p_rerun_hold)
    else $error("run rewrite reloaded the counter");

  property p_mod_pulse;
    @(posedge clk_i) disable iff (rst_i)
      (st_ff.msel && step) |=> pulse_output_pin_o;
  endproperty
  a_mod_pulse: assert property (p_mod_pulse)
    else $error("modulator step gave no pin pulse");

  property p_mod_quiet;
    @(posedge clk_i) disable iff (rst_i)
      (st_ff.msel && !st_ff.run) |=> !pulse_output_pin_o;
  endproperty
  a_mod_quiet: assert property (p_mod_quiet)
    else $error("stopped modulator still drives the pin");

  property p_half_hold;
    @(posedge clk_i) disable iff (rst_i)
      (step && half_mode && st_ff.cnt != 8'h00 && !wr_ctl)
        |=> (st_ff.cnt == $past(st_ff.cnt) - 8'h01)
            && (pulse_output_pin_o == $past(st_ff.pin));
  endproperty
  a_half_hold: assert property (p_half_hold)
    else $error("square wave pin moved before underflow");

  property p_stop_low;
    @(posedge clk_i) disable iff (rst_i)
      (!st_ff.run && !st_ff.msel && !wr_ctl && !hw_set) |=> !pulse_output_pin_o;
  endproperty
  a_stop_low: assert property (p_stop_low)
    else $error("stopped pulse-width timer left the pin high");

  property p_vd_ignore;
    @(posedge clk_i) disable iff (rst_i)
      (timer_underflow_i && !vd_mode && !st_ff.run && !wr_ctl) |=> !st_ff.run;
  endproperty
  a_vd_ignore: assert property (p_vd_ignore)
    else $error("timer underflow started a counter outside variable duty");
endmodule

// ---- test/pmt_load.sv ----
// load model on the modulator pin: counts driven high cycles and rising edges
`timescale 1ns/1ps
module pmt_load (
  // clock
  input wire logic clk_i,
  // pin and its drive enable
  input wire logic pin_i,
  input wire logic en_i,
  // observed counts
  output int high_o,
  output int rise_o,
  output int gap_o
);
  logic last_ff = 1'b0;
  int since_ff = 0;
  // an undriven pin is not an output, so it is not counted
  always @(posedge clk_i) begin
    last_ff <= pin_i;
    if (en_i === 1'b1 && pin_i === 1'b1) begin
      high_o <= high_o + 1;
    end
    if (en_i === 1'b1 && pin_i === 1'b1 && last_ff !== 1'b1) begin
      rise_o <= rise_o + 1;
      gap_o <= since_ff;
      since_ff <= 1;
    end else begin
      since_ff <= since_ff + 1;
    end
  end
endmodule

// ---- test/tb_top.sv ----
// self-checking bench for the pulse modulator timer
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [11:0] adr_i = 12'h000;
  logic [3:0] sel_i = 4'h1;
  logic [3:0] wsel = 4'h1;
  logic [31:0] dat_i = 32'h00000000;
  logic tu_i = 1'b0;
  logic [31:0] dat_o;
  logic ack_o;
  logic pin_o;
  logic en_o;
  int high;
  int rise;
  int gap;
  int n_errors = 0;
  int comparisons = 0;
  logic [31:0] q;
  logic [31:0] q2;

  pmt_top #(.ADDR_W(12)) dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .timer_underflow_i(tu_i), .pulse_output_pin_o(pin_o), .pulse_output_en_o(en_o));
  pmt_load load (.clk_i(clk_i), .pin_i(pin_o), .en_i(en_o), .high_o(high), .rise_o(rise),
    .gap_o(gap));

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic check_span(input int got, input int lo, input int hi, input string what);
    comparisons++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("wrong value at %0t: %s got %0d", $time, what, got);
    end
  endtask

  // one classic cycle; waits for ack and checks that it comes on the second edge after the request
  task automatic wb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    sel_i <= wsel;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1);
    q = dat_o;
    check_span(n, 2, 2, "bus ack latency");
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task automatic t_reset();
    check({pin_o, en_o}, 2'b00, "pin after reset");
    // underflow outside variable duty must not start anything
    tu_i <= 1'b1;
    @(posedge clk_i);
    tu_i <= 1'b0;
    wb(1'b0, pmt_pkg::IDX_CTL, 8'h00);
    check(q, 32'h0, "control after reset");
    wb(1'b1, pmt_pkg::IDX_STAT, 8'hff);
    wb(1'b0, pmt_pkg::IDX_STAT, 8'h00);
    check(q, 32'h0, "status ignores writes and timer");
    wb(1'b1, pmt_pkg::IDX_RELOAD, 8'h5a);
    wsel = 4'h0;
    wb(1'b1, pmt_pkg::IDX_RELOAD, 8'h33);
    wsel = 4'h1;
    wb(1'b0, pmt_pkg::IDX_RELOAD, 8'h00);
    check(q, 32'h5a, "reload readback");
    wb(1'b1, 10'h0cd, 8'hff);
    wb(1'b0, 10'h0cd, 8'h00);
    check(q, 32'h0, "unmapped read");
    $display("reset and registers done");
  endtask

  task automatic t_burst(input logic [7:0] ctl, input logic [7:0] rel, input int nrise,
      input int ngap);
    int h0;
    int r0;
    wb(1'b1, pmt_pkg::IDX_RELOAD, rel);
    h0 = high;
    r0 = rise;
    wb(1'b1, pmt_pkg::IDX_CTL, ctl);
    repeat ((rel + 1) * 10 + 30) @(posedge clk_i);
    check_span(high - h0, rel + 1, rel + 1, "burst length");
    check_span(rise - r0, nrise, nrise, "burst edges");
    if (ngap > 0) check_span(gap, ngap, ngap, "step spacing");
    check(pin_o, 1'b0, "pin after burst");
    wb(1'b0, pmt_pkg::IDX_STAT, 8'h00);
    check(q[9], 1'b0, "run after burst");
    wb(1'b1, pmt_pkg::IDX_CTL, 8'h00);
    $display("burst mode %h done", ctl);
  endtask

  task automatic t_square();
    wb(1'b1, pmt_pkg::IDX_RELOAD, 8'h01);
    wb(1'b1, pmt_pkg::IDX_CTL, 8'h01);
    repeat (130) @(posedge clk_i);
    check_span(gap, 40, 40, "square period");
    wb(1'b1, pmt_pkg::IDX_CTL, 8'h01);
    repeat (90) @(posedge clk_i);
    check_span(gap, 40, 40, "square period after run rewrite");
    wb(1'b1, pmt_pkg::IDX_CTL, 8'h00);
    wb(1'b0, pmt_pkg::IDX_STAT, 8'h00);
    q2 = q;
    repeat (30) @(posedge clk_i);
    wb(1'b0, pmt_pkg::IDX_STAT, 8'h00);
    check(q, q2, "counter frozen");
    $display("square wave done");
  endtask

  task automatic t_vduty();
    int h0;
    wb(1'b1, pmt_pkg::IDX_RELOAD, 8'h02);
    wb(1'b1, pmt_pkg::IDX_CTL, 8'h02);
    h0 = high;
    // main timer in toggle auto-reload mode, seen here as one underflow pulse
    tu_i <= 1'b1;
    @(posedge clk_i);
    tu_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check(pin_o, 1'b1, "pin after timer underflow");
    wb(1'b0, pmt_pkg::IDX_STAT, 8'h00);
    check(q[9], 1'b1, "run set by timer");
    repeat (40) @(posedge clk_i);
    check_span(high - h0, 21, 31, "duty width");
    check(pin_o, 1'b0, "pin low after count");
    wb(1'b0, pmt_pkg::IDX_STAT, 8'h00);
    check(q[9], 1'b0, "run cleared");
    wb(1'b1, pmt_pkg::IDX_CTL, 8'h00);
    $display("variable duty done");
  endtask

  task automatic t_midreset();
    wb(1'b1, pmt_pkg::IDX_RELOAD, 8'h10);
    wb(1'b1, pmt_pkg::IDX_CTL, 8'h05);
    repeat (5) @(posedge clk_i);
    check(en_o, 1'b1, "pin owned while running");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    check({pin_o, en_o}, 2'b00, "pin after mid-run reset");
    wb(1'b0, pmt_pkg::IDX_CTL, 8'h00);
    check(q, 32'h0, "control after mid-run reset");
    wb(1'b0, pmt_pkg::IDX_RELOAD, 8'h00);
    check(q, {24'h000000, pmt_pkg::RELOAD_RST}, "reload after mid-run reset");
    $display("mid-run reset done");
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // whole run is about 3100 cycles; over six times that means a hang
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    complete_run();
  end

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_burst(8'h05, 8'h03, 4, 10);
    t_burst(8'h07, 8'hff, 1, 0);
    t_square();
    t_vduty();
    t_midreset();
    complete_run();
  end
endmodule
